// file: hdl/image_protection_unit.sv
// What this block does
// - Decrypt fetched flash data in hardware, whole/partial
// - AES-256 counter keystream in both modes; XTS mode only puts the byte address in the vector
// - 256-bit key from OTP, read/write protectable
// - Init vector: user upper half, address lower half
// - Key auto-loaded; protected key reads are denied
// - Eight entries, each own vector and mode
// - Remap virtual bus addresses to physical flash
`timescale 1ns/1ns
module image_protection_unit
  import flash_decrypt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [KEY_W-1:0] otp_key,
  input wire logic otp_key_valid,
  input wire logic otp_read_protect,
  input wire logic otp_write_protect,
  input wire logic key_rd_req,
  output logic [KEY_W-1:0] key_rd_data,
  output logic key_rd_denied,
  output logic key_loaded,
  input wire logic cfg_wr,
  input wire logic [ENTRY_IDX_W-1:0] cfg_idx,
  input wire logic cfg_remap_en,
  input wire logic cfg_decrypt_en,
  input wire logic cfg_mode,
  input wire logic [VEC_HALF_W-1:0] cfg_vector_hi,
  input wire logic [ADDR_W-1:0] cfg_virt_base,
  input wire logic [ADDR_W-1:0] cfg_size,
  input wire logic [ADDR_W-1:0] cfg_phys_base,
  input wire logic rd_req,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic rd_ready,
  output logic fl_req,
  output logic [ADDR_W-1:0] fl_addr,
  input wire logic fl_rvalid,
  input wire logic [BLOCK_W-1:0] fl_rdata,
  output logic resp_valid,
  output logic [BLOCK_W-1:0] resp_data
);
  // ==========================================================
  // Reset release
  logic rst_q1, rst_sync_n;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_q1 <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_sync_n <= rst_q1;
    end
  end

  // ==========================================================
  // Key store
  logic [KEY_W-1:0] key, next_key;
  logic next_key_loaded;
  logic [KEY_W-1:0] next_key_rd_data;
  logic next_key_rd_denied;

  always_comb begin
    next_key = key;
    next_key_loaded = key_loaded;
    if (otp_key_valid && !(key_loaded && otp_write_protect)) begin
      next_key = otp_key;
      next_key_loaded = 1'b1;
    end
    next_key_rd_data = '0;
    next_key_rd_denied = 1'b0;
    if (key_rd_req) begin
      if (otp_read_protect) begin
        next_key_rd_denied = 1'b1;
      end else begin
        next_key_rd_data = key;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      key <= '0;
      key_loaded <= 1'b0;
      key_rd_data <= '0;
      key_rd_denied <= 1'b0;
    end else begin
      key <= next_key;
      key_loaded <= next_key_loaded;
      key_rd_data <= next_key_rd_data;
      key_rd_denied <= next_key_rd_denied;
    end
  end

  // ==========================================================
  // Entry table
  logic [ENTRY_COUNT-1:0] e_remap, e_decrypt, e_mode, hit;
  logic [VEC_HALF_W-1:0] e_vector [ENTRY_COUNT];
  logic [ADDR_W-1:0] e_vbase [ENTRY_COUNT];
  logic [ADDR_W-1:0] e_size [ENTRY_COUNT];
  logic [ADDR_W-1:0] e_pbase [ENTRY_COUNT];

  for (genvar g = 0; g < ENTRY_COUNT; g++) begin : g_entry
    logic wr_this;
    assign wr_this = cfg_wr && (cfg_idx == ENTRY_IDX_W'(g));
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        e_remap[g] <= 1'b0;
        e_decrypt[g] <= 1'b0;
        e_mode[g] <= 1'b0;
        e_vector[g] <= '0;
        e_vbase[g] <= '0;
        e_size[g] <= '0;
        e_pbase[g] <= '0;
      end else if (wr_this) begin
        e_remap[g] <= cfg_remap_en;
        e_decrypt[g] <= cfg_decrypt_en;
        e_mode[g] <= cfg_mode;
        e_vector[g] <= cfg_vector_hi;
        e_vbase[g] <= cfg_virt_base;
        e_size[g] <= cfg_size;
        e_pbase[g] <= cfg_phys_base;
      end
    end
    assign hit[g] = (e_remap[g] || e_decrypt[g]) && (rd_addr >= e_vbase[g])
                    && ((rd_addr - e_vbase[g]) < e_size[g]);
  end

  // Lowest hitting entry wins
  logic any_hit;
  logic [ENTRY_IDX_W-1:0] hit_idx;

  always_comb begin
    any_hit = 1'b0;
    hit_idx = '0;
    for (int i = ENTRY_COUNT - 1; i >= 0; i--) begin
      if (hit[i]) begin
        any_hit = 1'b1;
        hit_idx = ENTRY_IDX_W'(i);
      end
    end
  end

  // ==========================================================
  // Fetch sequencer
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_CIPHER,
    ST_RESP
  } fetch_state_t;

  fetch_state_t state, next_state;
  logic next_rd_ready, next_fl_req, next_resp_valid;
  logic [ADDR_W-1:0] next_fl_addr;
  logic [BLOCK_W-1:0] next_resp_data;
  logic [BLOCK_W-1:0] cipher_buf, next_cipher_buf;
  logic [BLOCK_W-1:0] ctr_block, next_ctr_block;
  logic do_decrypt, next_do_decrypt;
  logic aes_start, next_aes_start;
  logic aes_busy, aes_done;
  logic [BLOCK_W-1:0] aes_out;

  always_comb begin
    logic [ADDR_W-1:0] phys;
    logic [VEC_HALF_W-1:0] lo;
    phys = rd_addr;
    if (any_hit && e_remap[hit_idx]) begin
      phys = rd_addr - e_vbase[hit_idx] + e_pbase[hit_idx];
    end
    lo = (e_mode[hit_idx] == MODE_XTS) ? VEC_HALF_W'(phys)
                                       : VEC_HALF_W'(phys >> BLOCK_SHIFT);
    next_state = state;
    next_rd_ready = 1'b0;
    next_fl_req = fl_req;
    next_fl_addr = fl_addr;
    next_resp_valid = 1'b0;
    next_resp_data = resp_data;
    next_cipher_buf = cipher_buf;
    next_ctr_block = ctr_block;
    next_do_decrypt = do_decrypt;
    next_aes_start = 1'b0;
    case (state)
      ST_IDLE: begin
        next_rd_ready = 1'b1;
        if (rd_req && rd_ready) begin
          next_rd_ready = 1'b0;
          next_fl_req = 1'b1;
          next_fl_addr = phys;
          next_do_decrypt = any_hit && e_decrypt[hit_idx] && key_loaded;
          next_ctr_block = {e_vector[hit_idx], lo};
          next_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (fl_rvalid) begin
          next_fl_req = 1'b0;
          next_cipher_buf = fl_rdata;
          if (do_decrypt) begin
            next_aes_start = 1'b1;
            next_state = ST_CIPHER;
          end else begin
            next_resp_data = fl_rdata;
            next_resp_valid = 1'b1;
            next_state = ST_RESP;
          end
        end
      end
      ST_CIPHER: begin
        if (aes_done && !aes_busy) begin
          next_resp_data = cipher_buf ^ aes_out;
          next_resp_valid = 1'b1;
          next_state = ST_RESP;
        end
      end
      ST_RESP: begin
        next_rd_ready = 1'b1;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= ST_IDLE;
      rd_ready <= 1'b0;
      fl_req <= 1'b0;
      fl_addr <= '0;
      resp_valid <= 1'b0;
      resp_data <= '0;
      cipher_buf <= '0;
      ctr_block <= '0;
      do_decrypt <= 1'b0;
      aes_start <= 1'b0;
    end else begin
      state <= next_state;
      rd_ready <= next_rd_ready;
      fl_req <= next_fl_req;
      fl_addr <= next_fl_addr;
      resp_valid <= next_resp_valid;
      resp_data <= next_resp_data;
      cipher_buf <= next_cipher_buf;
      ctr_block <= next_ctr_block;
      do_decrypt <= next_do_decrypt;
      aes_start <= next_aes_start;
    end
  end

  // ==========================================================
  // Keystream engine
  aes256_encrypt_core u_flash_decrypt_engine (
    .clk_sys(clk_sys),
    .rst_sync_n(rst_sync_n),
    .start(aes_start),
    .key(key),
    .block_in(ctr_block),
    .busy(aes_busy),
    .done(aes_done),
    .block_out(aes_out)
  );
endmodule

// file: hdl/flash_decrypt_pkg.sv
package flash_decrypt_pkg;
  // ==========================================================
  // Sizes
  localparam int ENTRY_COUNT = 8;
  localparam int ENTRY_IDX_W = 3;
  localparam int ADDR_W = 32;
  localparam int BLOCK_W = 128;
  localparam int KEY_W = 256;
  localparam int VEC_HALF_W = 64;
  localparam int BLOCK_SHIFT = 4;
  // ==========================================================
  // Cipher constants
  localparam int AES_ROUNDS = 14;
  localparam logic [3:0] ROUND_LAST = 4'he;
  localparam logic [7:0] SBOX_AFFINE = 8'h63;
  localparam logic [7:0] RCON_FIRST = 8'h01;
  localparam logic [7:0] GF_POLY = 8'h1b;
  // ==========================================================
  // Entry modes
  typedef enum logic {
    MODE_CTR,
    MODE_XTS
  } cipher_mode_t;
endpackage

// file: hdl/aes256_encrypt_core.sv
`timescale 1ns/1ns
module aes256_encrypt_core
  import flash_decrypt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_sync_n,
  input wire logic start,
  input wire logic [KEY_W-1:0] key,
  input wire logic [BLOCK_W-1:0] block_in,
  output logic busy,
  output logic done,
  output logic [BLOCK_W-1:0] block_out
);
  // ==========================================================
  // Field arithmetic
  function automatic logic [7:0] xtime(input logic [7:0] a);
    xtime = {a[6:0], 1'b0} ^ (a[7] ? GF_POLY : 8'h00);
  endfunction

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] acc;
    logic [7:0] sh;
    acc = 8'h00;
    sh = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        acc = acc ^ sh;
      end
      sh = xtime(sh);
    end
    gmul = acc;
  endfunction

  function automatic logic [7:0] sbox(input logic [7:0] x);
    logic [7:0] x2, x3, x12, x15, x240, inv;
    x2 = gmul(x, x);
    x3 = gmul(x2, x);
    x12 = gmul(gmul(x3, x3), gmul(x3, x3));
    x15 = gmul(x12, x3);
    x240 = gmul(gmul(gmul(x15, x15), gmul(x15, x15)), gmul(gmul(x15, x15), gmul(x15, x15)));
    x240 = gmul(x240, x240);
    x240 = gmul(gmul(x15, x15), gmul(x15, x15));
    x240 = gmul(gmul(x240, x240), gmul(x240, x240));
    inv = gmul(gmul(x240, x12), x2);
    sbox = inv ^ {inv[6:0], inv[7]} ^ {inv[5:0], inv[7:6]} ^ {inv[4:0], inv[7:5]} ^ {inv[3:0], inv[7:4]} ^ SBOX_AFFINE;
  endfunction

  function automatic logic [31:0] sub_word(input logic [31:0] w);
    sub_word = {sbox(w[31:24]), sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0])};
  endfunction

  // ==========================================================
  // State
  logic [BLOCK_W-1:0] st, next_st;
  logic [KEY_W-1:0] win, next_win;
  logic [3:0] round, next_round;
  logic [7:0] rcon, next_rcon;
  logic phase_b, next_phase_b;
  logic next_busy, next_done;

  always_comb begin
    logic [31:0] t;
    logic [31:0] w0, w1, w2, w3;
    logic [BLOCK_W-1:0] sr;
    logic [BLOCK_W-1:0] mc;
    logic [7:0] a0, a1, a2, a3;
    sr = '0;
    mc = '0;
    a0 = 8'h00;
    a1 = 8'h00;
    a2 = 8'h00;
    a3 = 8'h00;
    t = phase_b ? sub_word(win[31:0]) : (sub_word({win[23:0], win[31:24]}) ^ {rcon, 24'h000000});
    w0 = win[255:224] ^ t;
    w1 = win[223:192] ^ w0;
    w2 = win[191:160] ^ w1;
    w3 = win[159:128] ^ w2;
    for (int i = 0; i < 16; i++) begin
      sr[127-8*i -: 8] = sbox(st[127-8*(((i/4 + i%4) % 4)*4 + i%4) -: 8]);
    end
    for (int c = 0; c < 4; c++) begin
      a0 = sr[127-32*c -: 8];
      a1 = sr[119-32*c -: 8];
      a2 = sr[111-32*c -: 8];
      a3 = sr[103-32*c -: 8];
      mc[127-32*c -: 8] = xtime(a0) ^ xtime(a1) ^ a1 ^ a2 ^ a3;
      mc[119-32*c -: 8] = a0 ^ xtime(a1) ^ xtime(a2) ^ a2 ^ a3;
      mc[111-32*c -: 8] = a0 ^ a1 ^ xtime(a2) ^ xtime(a3) ^ a3;
      mc[103-32*c -: 8] = xtime(a0) ^ a0 ^ a1 ^ a2 ^ xtime(a3);
    end
    next_st = st;
    next_win = win;
    next_round = round;
    next_rcon = rcon;
    next_phase_b = phase_b;
    next_busy = busy;
    next_done = 1'b0;
    if (start && !busy) begin
      next_st = block_in ^ key[255:128];
      next_win = key;
      next_round = 4'h1;
      next_rcon = RCON_FIRST;
      next_phase_b = 1'b0;
      next_busy = 1'b1;
    end else if (busy) begin
      next_win = {win[127:0], w0, w1, w2, w3};
      next_phase_b = !phase_b;
      if (!phase_b) begin
        next_rcon = xtime(rcon);
      end
      next_st = ((round == ROUND_LAST) ? sr : mc) ^ win[127:0];
      next_round = round + 4'h1;
      if (round == ROUND_LAST) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st <= '0;
      win <= '0;
      round <= 4'h0;
      rcon <= 8'h00;
      phase_b <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      st <= next_st;
      win <= next_win;
      round <= next_round;
      rcon <= next_rcon;
      phase_b <= next_phase_b;
      busy <= next_busy;
      done <= next_done;
    end
  end

  assign block_out = st;
endmodule

// file: dv/image_protection_unit_properties.sv
`timescale 1ns/1ns
module image_protection_unit_properties
  import flash_decrypt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic otp_key_valid,
  input wire logic otp_read_protect,
  input wire logic key_rd_req,
  input wire logic [KEY_W-1:0] key_rd_data,
  input wire logic key_rd_denied,
  input wire logic key_loaded,
  input wire logic rd_req,
  input wire logic rd_ready,
  input wire logic fl_req,
  input wire logic [ADDR_W-1:0] fl_addr,
  input wire logic fl_rvalid,
  input wire logic resp_valid,
  input wire logic [BLOCK_W-1:0] resp_data
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Bus read steps
  sequence s_take;
    rd_req && rd_ready;
  endsequence
  sequence s_fetch;
    fl_req && fl_rvalid;
  endsequence
  property p_take;
    s_take |=> !rd_ready && fl_req;
  endproperty
  property p_hold;
    fl_req && !fl_rvalid |=> fl_req && $stable(fl_addr);
  endproperty
  property p_answer;
    s_fetch |-> ##[1:17] resp_valid;
  endproperty
  property p_pulse;
    resp_valid |=> !resp_valid && rd_ready;
  endproperty
  property p_held;
    !resp_valid |-> $stable(resp_data);
  endproperty
  // ==========================================================
  // Key store
  property p_deny;
    key_rd_req && otp_read_protect |=> key_rd_denied && key_rd_data == '0;
  endproperty
  property p_load;
    otp_key_valid |=> key_loaded;
  endproperty
  property p_keep;
    key_loaded |=> key_loaded;
  endproperty
  a_take: assert property (p_take) else $error("read not taken");
  a_hold: assert property (p_hold) else $error("flash request dropped");
  a_answer: assert property (p_answer) else $error("late response");
  a_pulse: assert property (p_pulse) else $error("response not one cycle");
  a_held: assert property (p_held) else $error("response data moved");
  a_deny: assert property (p_deny) else $error("protected key leaked");
  a_load: assert property (p_load) else $error("key not loaded");
  a_keep: assert property (p_keep) else $error("key lost");
endmodule
bind image_protection_unit image_protection_unit_properties u_image_protection_unit_properties (
  .clk_sys(clk_sys), .rst_n(rst_n), .otp_key_valid(otp_key_valid), .otp_read_protect(otp_read_protect),
  .key_rd_req(key_rd_req), .key_rd_data(key_rd_data), .key_rd_denied(key_rd_denied), .key_loaded(key_loaded),
  .rd_req(rd_req), .rd_ready(rd_ready), .fl_req(fl_req), .fl_addr(fl_addr), .fl_rvalid(fl_rvalid),
  .resp_valid(resp_valid), .resp_data(resp_data)
);

// file: dv/flash_model.sv
`timescale 1ns/1ns
module flash_model
  import flash_decrypt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic fl_req,
  input wire logic [ADDR_W-1:0] fl_addr,
  input wire logic [ADDR_W-1:0] salt,
  input wire logic [3:0] lat,
  output logic fl_rvalid,
  output logic [BLOCK_W-1:0] fl_rdata
);
  logic [3:0] cnt;
  logic done;
  // ==========================================================
  // Answers after lat cycles; data bus toggles when idle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      done <= 1'b0;
      fl_rvalid <= 1'b0;
      fl_rdata <= '1;
    end else begin
      if (fl_req && !done && cnt >= lat) begin
        fl_rvalid <= 1'b1;
        fl_rdata <= {4{fl_addr ^ salt}};
      end else begin
        fl_rvalid <= 1'b0;
        fl_rdata <= ~fl_rdata;
      end
      if (!fl_req) begin
        cnt <= '0;
        done <= 1'b0;
      end else if (!done && cnt >= lat) begin
        done <= 1'b1;
      end else if (!done) begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

// file: dv/flash_inline_decrypt_test.sv
`timescale 1ns/1ns
module flash_inline_decrypt_test;
  import flash_decrypt_pkg::*;
  logic clk_sys = 0, rst_n = 0, otp_key_valid = 0, otp_read_protect = 0, otp_write_protect = 0;
  logic key_rd_req = 0, cfg_wr = 0, cfg_remap_en = 0, cfg_decrypt_en = 0, cfg_mode = 0, rd_req = 0;
  logic key_rd_denied, key_loaded, rd_ready, fl_req, fl_rvalid, resp_valid, den;
  logic [KEY_W-1:0] otp_key = '0, key_rd_data, k1, kd;
  logic [ENTRY_IDX_W-1:0] cfg_idx = '0;
  logic [VEC_HALF_W-1:0] cfg_vector_hi = '0;
  logic [ADDR_W-1:0] cfg_virt_base = '0, cfg_size = '0, cfg_phys_base = '0, rd_addr = '0, salt = '0;
  logic [ADDR_W-1:0] fl_addr, fa, a, seed = 32'h49;
  logic [ADDR_W-1:0] rmp [4] = '{32'h1000_0000, 32'h1000_0ff0, 32'h1000_1000, 32'h0fff_fff0};
  logic [BLOCK_W-1:0] fl_rdata, resp_data, d1, d2, d3, r1;
  logic [3:0] lat = '0;
  int bad_count = 0, n_checks = 0, i;
  image_protection_unit u_image_protection_unit (.*);
  flash_model u_flash_model (.*);
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [BLOCK_W-1:0] raw(input logic [ADDR_W-1:0] pa);
    return {4{pa ^ salt}};
  endfunction
  function automatic logic [ADDR_W-1:0] phys(input logic [ADDR_W-1:0] va);
    return (va >= 32'h1000_0000 && va < 32'h1000_1000) ? va - 32'h0800_0000 : va;
  endfunction
  task automatic give_verdict();
    if (bad_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [BLOCK_W-1:0] got, input logic [BLOCK_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [ADDR_W-1:0] va, output logic [BLOCK_W-1:0] d, output logic [ADDR_W-1:0] pa);
    int n;
    n = 0;
    @(posedge clk_sys);
    rd_req <= 1'b1;
    rd_addr <= va;
    lat <= 4'(rnd() % 6);
    do begin
      @(posedge clk_sys);
      n++;
    end while (rd_ready !== 1'b1 && n < 50);
    rd_req <= 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
      if (fl_rvalid === 1'b1 && fl_req === 1'b1)
        pa = fl_addr;
    end while (resp_valid !== 1'b1 && n < 90);
    if (n >= 90) begin
      bad_count++;
      give_verdict();
    end
    d = resp_data;
  endtask
  task automatic cfg(input int idx, input logic rm, input logic dec, input logic [ADDR_W-1:0] vb);
    @(posedge clk_sys);
    cfg_wr <= 1'b1;
    cfg_idx <= idx[2:0];
    cfg_remap_en <= rm;
    cfg_decrypt_en <= dec;
    cfg_mode <= idx[0];
    cfg_vector_hi <= {rnd(), rnd()};
    cfg_virt_base <= vb;
    cfg_size <= rm ? 32'h1000 : 32'h100;
    cfg_phys_base <= 32'h0800_0000;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
  endtask
  task automatic kload(input logic [KEY_W-1:0] k);
    @(posedge clk_sys);
    otp_key <= k;
    otp_key_valid <= 1'b1;
    @(posedge clk_sys);
    otp_key_valid <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic kread();
    @(posedge clk_sys);
    key_rd_req <= 1'b1;
    @(posedge clk_sys);
    key_rd_req <= 1'b0;
    @(posedge clk_sys);
    kd = key_rd_data;
    den = key_rd_denied;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    for (i = 0; i < 8; i++)
      k1 = {k1[KEY_W-33:0], rnd()};
    kload(k1);
    chk(BLOCK_W'(key_loaded), 128'h1);
    kread();
    chk(kd[127:0], k1[127:0]);
    chk(kd[255:128], k1[255:128]);
    chk(BLOCK_W'(den), 128'h0);
    otp_write_protect <= 1'b1;
    kload(~k1);
    kread();
    chk(kd[255:128], k1[255:128]);
    chk(kd[127:0], k1[127:0]);
    otp_read_protect <= 1'b1;
    kread();
    chk(kd[255:128] | kd[127:0], 128'h0);
    chk(BLOCK_W'(den), 128'h1);
    for (i = 0; i < 6; i++) begin
      salt <= rnd();
      a = (i == 0) ? 32'h0 : rnd();
      rd(a, d1, fa);
      chk(BLOCK_W'(fa), BLOCK_W'(a));
      chk(d1, raw(a));
    end
    cfg(0, 1'b1, 1'b0, 32'h1000_0000);
    for (i = 0; i < 4; i++) begin
      rd(rmp[i], d1, fa);
      chk(BLOCK_W'(fa), BLOCK_W'(phys(rmp[i])));
      chk(d1, raw(phys(rmp[i])));
    end
    for (i = 0; i < 8; i++) begin
      a = 32'h2000_0000 + (ADDR_W'(i) << 8) + (rnd() & 32'hf0);
      cfg(i, 1'b0, 1'b1, 32'h2000_0000 + (ADDR_W'(i) << 8));
      salt <= rnd();
      rd(a, d1, fa);
      r1 = raw(a);
      chk(BLOCK_W'(d1 == r1), 128'h0);
      salt <= rnd();
      rd(a, d2, fa);
      chk(d1 ^ d2, r1 ^ raw(a));
      chk(BLOCK_W'(fa), BLOCK_W'(a));
      rd(a ^ 32'h10, d3, fa);
      chk(BLOCK_W'((d3 ^ raw(a ^ 32'h10)) == (d2 ^ raw(a))), 128'h0);
      cfg(i, 1'b0, 1'b1, 32'h2000_0000 + (ADDR_W'(i) << 8));
      rd(a, d3, fa);
      chk(BLOCK_W'(d3 == d2), 128'h0);
    end
    rd(32'h2000_0800, d1, fa);
    chk(d1, raw(32'h2000_0800));
    give_verdict();
  end
endmodule
